// File: otpsec_core.sv
/*
 OTP array with its security register, boot loader, processor
 programming ports and boundary-scan identification port.
 Assumes one 50 MHz clock; scan pins are asynchronous and are synchronised
 here, so the scan clock must run well below a quarter of REF_CLK_I.
*/
// Contract
// R1: 8 KB OTP, four sectors of 512x32
// R2: Security word loaded first after power-up
// R3: Remaining OTP copied to SRAM, run first
// R4: Row address via 16-bit port 0x100200
// R5: Program data via 32-bit port 0x200100
// R6: Program control via 16-bit port 0x100300
// R7: Bit 0 disables the scan port
// R8: Bit 1 refuses link access to state
// R9: Bit 5 boots from OTP address 0
// R10: Bit 7 enables redundant rows
// R11: Bits 8-11 lock sectors 0-3
// R12: Bit 12 locks all programming
// R13: Bit 13 blocks scan OTP access
// R14: Bits 21:15 software general purpose
// R15: Bits 31:22 extend scan user code
// R16: Scan port: 4-bit IR, 32-bit DR
// R17: Host holds scan reset low at power-up
// R18: Scan reset held low keeps port reset
// R19: SCAN_IDENTIFICATION: version, part, maker, one
// R20: USERCODE ID from security bits 31:22
// R21: User code: ID, unused, silicon revision
// R22: Secure bit clear boots from flash
// R23: Programmed ones never revert
`timescale 1ns/1ns
`default_nettype none
`include "otpsec_map.svh"
module otpsec_core
   import otpsec_pkg::*;
#(
   parameter logic [3:0] ID_VERSION = 4'h0,  // Arbitrary value
   parameter logic [15:0] ID_PART = 16'h0001, // Arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h055, // Arbitrary value
   parameter logic [17:0] SI_REVISION = 18'h28000
) (
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   input wire logic ADDR_WE_I,
   input wire logic [15:0] ADDR_I,
   input wire logic DATA_WE_I,
   input wire logic [31:0] DATA_I,
   input wire logic CTRL_WE_I,
   input wire logic [15:0] CTRL_I,
   output logic [15:0] CTRL_O,
   output logic [31:0] DATA_O,
   output logic [31:0] SEC_O,
   output logic LINK_ACCESS_EN_O,
   output logic BOOT_WE_O,
   output logic [10:0] BOOT_ADDR_O,
   output logic [31:0] BOOT_DATA_O,
   output logic CORE_RUN_O,
   output logic BOOT_OTP_O,
   input wire logic TCK_I,
   input wire logic TMS_I,
   input wire logic TDI_I,
   input wire logic TRST_N_I,
   output logic TDO_O,
   output logic TDO_OE_O
);
   // ------------------------------------------------------------------
   // Nonvolatile storage: no reset, blank reads zero
   // ------------------------------------------------------------------
   logic [31:0] otp_mem [0:`OTP_ROWS-1]; // [R1]
   logic [31:0] spare_mem [0:`OTP_SPARE_ROWS-1];
   logic [31:0] sec_cell;
   initial begin
      for (int i = 0; i < `OTP_ROWS; i++) otp_mem[i] = 32'h0;
      for (int i = 0; i < `OTP_SPARE_ROWS; i++) spare_mem[i] = 32'h0;
      sec_cell = 32'h0;
   end

   logic [31:0] sec_ff;
   otpsec_boot_t boot_ff;
   logic [10:0] copy_idx_ff;
   otpsec_prog_t prog_ff;
   logic [8:0] prog_cnt_ff;
   logic [15:0] addr_ff;
   logic [31:0] wdata_ff;
   logic sec_tgt_ff;
   logic done_ff, refused_ff;
   logic scan_req_ff;
   logic [11:0] scan_addr_ff;
   logic [31:0] scan_wdata_ff;

   // ------------------------------------------------------------------
   // Boot: security word, then copy of the array, then release
   // ------------------------------------------------------------------
   // Core stays held until the whole array is in SRAM
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         boot_ff <= OTPSEC_B_LOAD;
         sec_ff <= 32'h0;
         copy_idx_ff <= 11'h0;
         BOOT_WE_O <= 1'b0;
         BOOT_ADDR_O <= 11'h0;
         BOOT_DATA_O <= 32'h0;
         CORE_RUN_O <= 1'b0;
         BOOT_OTP_O <= 1'b0;
      end else begin
         BOOT_WE_O <= 1'b0;
         case (boot_ff)
            OTPSEC_B_LOAD: begin
               sec_ff <= sec_cell; // [R2]
               boot_ff <= OTPSEC_B_COPY;
            end
            OTPSEC_B_COPY: begin
               BOOT_WE_O <= 1'b1; // [R3]
               BOOT_ADDR_O <= copy_idx_ff;
               BOOT_DATA_O <= otp_mem[copy_idx_ff];
               copy_idx_ff <= copy_idx_ff + 11'h1;
               if (copy_idx_ff == 11'(`OTP_ROWS - 1)) begin
                  boot_ff <= OTPSEC_B_RUN;
               end
            end
            OTPSEC_B_RUN: begin
               CORE_RUN_O <= 1'b1; // [R3]
               BOOT_OTP_O <= sec_ff[`SEC_OTP_BOOT]; // [R9] [R22]
            end
            default: boot_ff <= OTPSEC_B_LOAD;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Programming permission
   // ------------------------------------------------------------------
   function automatic logic prog_ok(input logic [31:0] sec,
                                    input logic to_sec,
                                    input logic [15:0] adr);
      logic [1:0] sector;
      sector = adr[10:9];
      if (sec[`SEC_MASTER_LOCK]) prog_ok = 1'b0; // [R12]
      else if (to_sec) prog_ok = 1'b1;
      else if (adr[`ADR_SPARE]) prog_ok = sec[`SEC_SPARE_EN]; // [R10]
      else prog_ok = !sec[`SEC_LOCK_LSB + sector]; // [R11]
   endfunction : prog_ok

   wire booted = (boot_ff == OTPSEC_B_RUN);
   wire cpu_prog = CTRL_WE_I && CTRL_I[`CTL_PROG]; // [R6]
   wire cpu_read = CTRL_WE_I && CTRL_I[`CTL_READ];
   wire start_cpu = booted && cpu_prog && (prog_ff == OTPSEC_P_IDLE);
   wire start_scan = booted && scan_req_ff && !cpu_prog &&
                     (prog_ff == OTPSEC_P_IDLE);
   wire [15:0] nxt_addr = start_scan ? {4'h0, scan_addr_ff} : addr_ff;
   wire nxt_tgt = start_cpu && CTRL_I[`CTL_SEC];
   wire allow = prog_ok(sec_ff, nxt_tgt, nxt_addr);
   wire [31:0] rd_row = addr_ff[`ADR_SPARE] ?
                        spare_mem[addr_ff[3:0]] : otp_mem[addr_ff[10:0]];

   // ------------------------------------------------------------------
   // Processor ports and programming engine
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         addr_ff <= 16'h0;
         wdata_ff <= 32'h0;
         sec_tgt_ff <= 1'b0;
         prog_ff <= OTPSEC_P_IDLE;
         prog_cnt_ff <= 9'h0;
         done_ff <= 1'b0;
         refused_ff <= 1'b0;
         DATA_O <= 32'h0;
      end else begin
         if (ADDR_WE_I && prog_ff == OTPSEC_P_IDLE) addr_ff <= ADDR_I; // [R4]
         if (DATA_WE_I && prog_ff == OTPSEC_P_IDLE) wdata_ff <= DATA_I; // [R5]
         if (cpu_read) begin
            DATA_O <= CTRL_I[`CTL_SEC] ? sec_ff : rd_row; // [R14]
         end
         case (prog_ff)
            OTPSEC_P_IDLE: if (start_cpu || start_scan) begin
               done_ff <= 1'b0;
               refused_ff <= !allow;
               addr_ff <= nxt_addr;
               sec_tgt_ff <= nxt_tgt;
               if (start_scan) wdata_ff <= scan_wdata_ff;
               prog_cnt_ff <= 9'(`OTP_PROG_CYC - 1);
               prog_ff <= allow ? OTPSEC_P_PROG : OTPSEC_P_DONE;
            end
            OTPSEC_P_PROG: begin
               prog_cnt_ff <= prog_cnt_ff - 9'h1;
               if (prog_cnt_ff == 9'h0) prog_ff <= OTPSEC_P_DONE;
            end
            OTPSEC_P_DONE: begin
               done_ff <= 1'b1;
               prog_ff <= OTPSEC_P_IDLE;
            end
            default: prog_ff <= OTPSEC_P_IDLE;
         endcase
      end
   end

   // Cells only ever gain ones; a new security word waits for power-up
   // Plain always: the blank-array initial block also writes these cells
   always @(posedge REF_CLK_I) begin
      if (prog_ff == OTPSEC_P_PROG && prog_cnt_ff == 9'h0) begin
         if (sec_tgt_ff) sec_cell <= sec_cell | wdata_ff; // [R23]
         else if (addr_ff[`ADR_SPARE])
            spare_mem[addr_ff[3:0]] <= spare_mem[addr_ff[3:0]] | wdata_ff;
         else
            otp_mem[addr_ff[10:0]] <= otp_mem[addr_ff[10:0]] | wdata_ff;
      end
   end

   // ------------------------------------------------------------------
   // Status and security outputs
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         CTRL_O <= 16'h0;
         SEC_O <= 32'h0;
         LINK_ACCESS_EN_O <= 1'b0;
      end else begin
         CTRL_O <= {13'h0, refused_ff, done_ff,
                    prog_ff != OTPSEC_P_IDLE || !booted};
         SEC_O <= sec_ff;
         LINK_ACCESS_EN_O <= booted && !sec_ff[`SEC_LINK_OFF]; // [R8]
      end
   end

   // ------------------------------------------------------------------
   // Scan pins: two-stage synchronisers, edges from the second stage
   // ------------------------------------------------------------------
   logic [3:0] pin_s1_ff, pin_s2_ff;
   logic tck_d_ff;
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pin_s1_ff <= 4'h0;
         pin_s2_ff <= 4'h0;
         tck_d_ff <= 1'b0;
      end else begin
         pin_s1_ff <= {TRST_N_I, TDI_I, TMS_I, TCK_I};
         pin_s2_ff <= pin_s1_ff;
         tck_d_ff <= pin_s2_ff[0];
      end
   end
   wire tck_rise = pin_s2_ff[0] && !tck_d_ff;
   wire tck_fall = !pin_s2_ff[0] && tck_d_ff;
   wire tms = pin_s2_ff[1];
   wire tdi = pin_s2_ff[2];
   // Port held in reset by its own reset pin, by the disable bit or until boot ends
   wire tap_hold = !pin_s2_ff[3] || sec_ff[`SEC_SCAN_OFF] || !booted; // [R7] [R18]

   // ------------------------------------------------------------------
   // Test access port
   // ------------------------------------------------------------------
   function automatic otpsec_tap_t tap_next(input otpsec_tap_t s,
                                            input logic m);
      case (s)
         OTPSEC_T_RESET: tap_next = m ? OTPSEC_T_RESET : OTPSEC_T_IDLE;
         OTPSEC_T_IDLE: tap_next = m ? OTPSEC_T_SDRS : OTPSEC_T_IDLE;
         OTPSEC_T_SDRS: tap_next = m ? OTPSEC_T_SIRS : OTPSEC_T_CDR;
         OTPSEC_T_CDR, OTPSEC_T_SDR:
            tap_next = m ? OTPSEC_T_E1DR : OTPSEC_T_SDR;
         OTPSEC_T_E1DR: tap_next = m ? OTPSEC_T_UDR : OTPSEC_T_PDR;
         OTPSEC_T_PDR: tap_next = m ? OTPSEC_T_E2DR : OTPSEC_T_PDR;
         OTPSEC_T_E2DR: tap_next = m ? OTPSEC_T_UDR : OTPSEC_T_SDR;
         OTPSEC_T_SIRS: tap_next = m ? OTPSEC_T_RESET : OTPSEC_T_CIR;
         OTPSEC_T_CIR, OTPSEC_T_SIR:
            tap_next = m ? OTPSEC_T_E1IR : OTPSEC_T_SIR;
         OTPSEC_T_E1IR: tap_next = m ? OTPSEC_T_UIR : OTPSEC_T_PIR;
         OTPSEC_T_PIR: tap_next = m ? OTPSEC_T_E2IR : OTPSEC_T_PIR;
         OTPSEC_T_E2IR: tap_next = m ? OTPSEC_T_UIR : OTPSEC_T_SIR;
         OTPSEC_T_UDR, OTPSEC_T_UIR:
            tap_next = m ? OTPSEC_T_SDRS : OTPSEC_T_IDLE;
         default: tap_next = OTPSEC_T_RESET;
      endcase
   endfunction : tap_next

   otpsec_tap_t tap_ff;
   logic [`IR_BITS-1:0] ir_ff, ir_sh_ff; // [R16]
   logic [`DR_BITS-1:0] dr_sh_ff; // [R16]
   wire scan_otp_ok = !sec_ff[`SEC_SCAN_OTP_OFF]; // [R13]
   wire [31:0] id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1}; // [R19]
   // Scan reads follow the scan address, not the processor's
   wire [31:0] scan_row = scan_addr_ff[`ADR_SPARE] ?
                          spare_mem[scan_addr_ff[3:0]] :
                          otp_mem[scan_addr_ff[10:0]];
   wire [31:0] user_word = {sec_ff[`SEC_UID_MSB:`SEC_UID_LSB], 4'h0,
                            SI_REVISION}; // [R15] [R20] [R21]
   wire [31:0] cap_word =
      (ir_ff == `IR_SCAN_IDENTIFICATION) ? id_word :
      (ir_ff == `IR_USERCODE) ? user_word :
      (ir_ff == `IR_OTPDATA && scan_otp_ok) ? scan_row : 32'h0; // [R13]
   wire bypass = (ir_ff == `IR_BYPASS) || (ir_ff == 4'h0);

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         tap_ff <= OTPSEC_T_RESET;
         ir_ff <= `IR_SCAN_IDENTIFICATION;
         ir_sh_ff <= 4'h0;
         dr_sh_ff <= 32'h0;
         scan_addr_ff <= 12'h0;
         scan_wdata_ff <= 32'h0;
         scan_req_ff <= 1'b0;
      end else begin
         if (start_scan) scan_req_ff <= 1'b0;
         if (tap_hold) begin
            tap_ff <= OTPSEC_T_RESET;
            ir_ff <= `IR_SCAN_IDENTIFICATION;
            scan_req_ff <= 1'b0;
         end else if (tck_rise) begin
            tap_ff <= tap_next(tap_ff, tms);
            case (tap_ff)
               OTPSEC_T_RESET: ir_ff <= `IR_SCAN_IDENTIFICATION;
               OTPSEC_T_CIR: ir_sh_ff <= 4'h1;
               OTPSEC_T_SIR: ir_sh_ff <= {tdi, ir_sh_ff[3:1]};
               OTPSEC_T_UIR: ir_ff <= ir_sh_ff;
               OTPSEC_T_CDR: dr_sh_ff <= cap_word;
               OTPSEC_T_SDR: dr_sh_ff <= bypass ? {31'h0, tdi} :
                                         {tdi, dr_sh_ff[31:1]};
               OTPSEC_T_UDR: begin
                  if (ir_ff == `IR_OTPADDR) scan_addr_ff <= dr_sh_ff[11:0];
                  if (ir_ff == `IR_OTPDATA && scan_otp_ok) begin // [R13]
                     scan_wdata_ff <= dr_sh_ff;
                     scan_req_ff <= 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Output changes on the falling edge, as the host samples on rising
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         TDO_O <= 1'b0;
         TDO_OE_O <= 1'b0;
      end else if (tap_hold) begin
         TDO_O <= 1'b0;
         TDO_OE_O <= 1'b0; // [R7]
      end else if (tck_fall) begin
         TDO_O <= (tap_ff == OTPSEC_T_SIR) ? ir_sh_ff[0] : dr_sh_ff[0];
         TDO_OE_O <= (tap_ff == OTPSEC_T_SIR) || (tap_ff == OTPSEC_T_SDR);
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_link_gate: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
      sec_ff[`SEC_LINK_OFF] |=> !LINK_ACCESS_EN_O) // [R8]
      else $error("link access open while refused");
   a_scan_off: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
      sec_ff[`SEC_SCAN_OFF] |=> !TDO_OE_O && tap_ff == OTPSEC_T_RESET) // [R7]
      else $error("scan port active while disabled");
   a_master_lock: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
      (start_cpu || start_scan) && sec_ff[`SEC_MASTER_LOCK]
      |=> prog_ff == OTPSEC_P_DONE && refused_ff) // [R12]
      else $error("programming ran under master lock");
   a_sector_lock: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
      start_cpu && !nxt_tgt && !nxt_addr[`ADR_SPARE]
      && sec_ff[`SEC_LOCK_LSB + nxt_addr[10:9]]
      |=> refused_ff ##1 done_ff) // [R11]
      else $error("locked sector accepted programming");
   a_spare_gate: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
      start_cpu && !nxt_tgt && nxt_addr[`ADR_SPARE]
      |=> refused_ff == !$past(sec_ff[`SEC_SPARE_EN])) // [R10]
      else $error("spare rows gate wrong");
   a_boot_src: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
      $rose(CORE_RUN_O) |-> BOOT_OTP_O == sec_ff[`SEC_OTP_BOOT]) // [R9] [R22]
      else $error("boot source does not follow secure bit");
   a_load_first: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
      $rose(BOOT_WE_O) |-> BOOT_ADDR_O == 11'h0 && sec_ff == sec_cell) // [R2]
      else $error("copy began before security load");
   a_copy_len: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
      BOOT_WE_O && BOOT_ADDR_O == 11'h7ff |=> !BOOT_WE_O ##1 CORE_RUN_O) // [R3]
      else $error("core released at wrong point of copy");
   a_sticky_sec: assert property (@(posedge REF_CLK_I)
      (($past(sec_cell) & ~sec_cell) == 32'h0)) // [R23]
      else $error("programmed security bit reverted");
   a_scan_otp: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
      sec_ff[`SEC_SCAN_OTP_OFF] && ir_ff == `IR_OTPDATA
      && tap_ff == OTPSEC_T_CDR && tck_rise && !tap_hold
      |=> dr_sh_ff == 32'h0) // [R13]
      else $error("scan read OTP while blocked");
endmodule : otpsec_core
`default_nettype wire

// File: otpsec_host.sv
/*
 Scan host model: drives the test access port pins of the block.
 Assumes the scan clock runs far below the block clock.
*/
`timescale 1ns/1ns
`default_nettype none
module otpsec_host (
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic trst_n_o,
   input wire logic tdo_i,
   input wire logic tdo_oe_i
);
   // ----------------
   // Pin activity
   // ----------------
   // Scan clock stands still between frames; reset held from power-up
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
      trst_n_o = 1'b0;
   end
   // One scan clock of 16 block clocks, four times the synchroniser minimum
   task automatic tick(input logic ms, input logic di, output logic q);
      tms_o = ms;
      tdi_o = di;
      #160 q = tdo_i;
      tck_o = 1'b1;
      #160 tck_o = 1'b0;
   endtask : tick
   // Release reset after the hold time, then park in idle
   task automatic start();
      logic q;
      #400 trst_n_o = 1'b1;
      repeat (5) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask : start
   // Shift 4 instruction or 32 data bits, LSB first, idle to idle
   task automatic scan(input logic ir, input logic [31:0] din,
                       output logic [31:0] dout, output logic oe);
      logic q;
      int n;
      n = ir ? 4 : 32;
      dout = '0;
      oe = 1'b0;
      tick(1'b1, 1'b0, q);
      if (ir) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
      tick(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
         oe = oe | tdo_oe_i;
      end
      tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask : scan
endmodule : otpsec_host
`default_nettype wire

// File: otpsec_map.svh
/*
 Constants of the OTP security and scan identification block: sizes,
 field positions, port encodings, instruction codes and timing counts.
 Assumes inclusion by otpsec_pkg.sv and otpsec_core.sv only.
*/
`ifndef OTPSEC_MAP_SVH
`define OTPSEC_MAP_SVH
// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define OTP_ROWS 2048
`define OTP_SECTOR_ROWS 512
`define OTP_SPARE_ROWS 16
`define OTP_SECTORS 4
// ----------------------------------------------------------------------
// Security register fields
// ----------------------------------------------------------------------
`define SEC_SCAN_OFF 0
`define SEC_LINK_OFF 1
`define SEC_OTP_BOOT 5
`define SEC_SPARE_EN 7
`define SEC_LOCK_LSB 8
`define SEC_MASTER_LOCK 12
`define SEC_SCAN_OTP_OFF 13
`define SEC_GP_MSB 21
`define SEC_GP_LSB 15
`define SEC_UID_MSB 31
`define SEC_UID_LSB 22
// ----------------------------------------------------------------------
// Processor port resource identifiers
// ----------------------------------------------------------------------
`define RES_OTP_ADDR 24'h100200
`define RES_OTP_DATA 24'h200100
`define RES_OTP_CTRL 24'h100300
// ----------------------------------------------------------------------
// Control port bits (write) and status bits (read)
// ----------------------------------------------------------------------
`define CTL_PROG 0
`define CTL_READ 1
`define CTL_SEC 2
`define STS_BUSY 0
`define STS_DONE 1
`define STS_REFUSED 2
// Address port: bit 11 selects the spare rows
`define ADR_SPARE 11
// ----------------------------------------------------------------------
// Scan port
// ----------------------------------------------------------------------
`define IR_BITS 4
`define DR_BITS 32
`define IR_SCAN_IDENTIFICATION 4'h1
`define IR_USERCODE 4'h8
`define IR_OTPADDR 4'h6
`define IR_OTPDATA 4'h7
`define IR_BYPASS 4'hf
// ----------------------------------------------------------------------
// Timing at 50 MHz
// ----------------------------------------------------------------------
`define CLK_NS 20
`define OTP_PROG_NS 10000
`define OTP_PROG_CYC ((`OTP_PROG_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: otpsec_pkg.sv
/*
 Types of the OTP security and scan identification block.
 Assumes otpsec_map.svh is on the include path.
*/
`default_nettype none
package otpsec_pkg;
   `include "otpsec_map.svh"
   // ---------------------------------------------------------------
   // Boot sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OTPSEC_B_LOAD = 2'b00,
      OTPSEC_B_COPY = 2'b01,
      OTPSEC_B_RUN = 2'b10
   } otpsec_boot_t;
   // ---------------------------------------------------------------
   // Programming engine states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OTPSEC_P_IDLE = 2'b00,
      OTPSEC_P_PROG = 2'b01,
      OTPSEC_P_DONE = 2'b10
   } otpsec_prog_t;
   // ---------------------------------------------------------------
   // Test access port states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OTPSEC_T_RESET = 4'h0, OTPSEC_T_IDLE = 4'h1,
      OTPSEC_T_SDRS = 4'h2, OTPSEC_T_CDR = 4'h3,
      OTPSEC_T_SDR = 4'h4, OTPSEC_T_E1DR = 4'h5,
      OTPSEC_T_PDR = 4'h6, OTPSEC_T_E2DR = 4'h7,
      OTPSEC_T_UDR = 4'h8, OTPSEC_T_SIRS = 4'h9,
      OTPSEC_T_CIR = 4'ha, OTPSEC_T_SIR = 4'hb,
      OTPSEC_T_E1IR = 4'hc, OTPSEC_T_PIR = 4'hd,
      OTPSEC_T_E2IR = 4'he, OTPSEC_T_UIR = 4'hf
   } otpsec_tap_t;
endpackage : otpsec_pkg
`default_nettype wire

// File: otpsec_tb_top.sv
/*
 Self-checking bench of the OTP security block with a scan host model.
 Assumes otpsec_pkg and otpsec_host are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module otpsec_tb_top import otpsec_pkg::*;;
   localparam logic [3:0] VER = 4'h3; // Arbitrary value
   localparam logic [15:0] PART = 16'h00a5; // Arbitrary value
   localparam logic [10:0] MAKER = 11'h2c9; // Arbitrary value
   localparam logic [17:0] REV = 18'h28000;
   logic clk, nrst, awe, dwe, cwe, bwe, run, botp, link, tdo, toe;
   logic tck, tms, tdi, trst_n;
   logic [15:0] adr, ctl, sts;
   logic [31:0] din, dq, sec, bdata;
   logic [31:0] watch_d = '0;
   logic [10:0] baddr;
   int num_errors = 0;
   int n_compared = 0;
   int boot_n = 0;
   int boot_bad = 0;
   int cycles = 0;
   otpsec_core #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
      .SI_REVISION(REV)) DUT (.REF_CLK_I(clk), .NRST_I(nrst),
      .ADDR_WE_I(awe), .ADDR_I(adr), .DATA_WE_I(dwe), .DATA_I(din),
      .CTRL_WE_I(cwe), .CTRL_I(ctl), .CTRL_O(sts), .DATA_O(dq),
      .SEC_O(sec), .LINK_ACCESS_EN_O(link), .BOOT_WE_O(bwe),
      .BOOT_ADDR_O(baddr), .BOOT_DATA_O(bdata), .CORE_RUN_O(run),
      .BOOT_OTP_O(botp), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
      .TRST_N_I(trst_n), .TDO_O(tdo), .TDO_OE_O(toe));
   otpsec_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .trst_n_o(trst_n), .tdo_i(tdo), .tdo_oe_i(toe));
   // ----------------
   // Clock, monitors
   // ----------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Copy pulses must climb from address zero; row 0x3ff is kept
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         print_verdict();
      end
      if (bwe === 1'b1) begin
         if (baddr !== boot_n[10:0]) boot_bad++;
         if (baddr === 11'h3ff) watch_d = bdata;
         boot_n++;
      end
   end
   // ----------------
   // Tasks
   // ----------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   // Reset, then wait out the whole boot copy and the busy flag
   task automatic do_reset();
      nrst = 1'b0;
      boot_n = 0;
      cyc(20);
      check({sts, 15'h0, run}, 32'h0);
      nrst = 1'b1;
      for (int i = 0; i < 3000 && run !== 1'b1; i++) cyc(1);
      for (int i = 0; i < 100 && sts[0] !== 1'b0; i++) cyc(1);
      check(boot_n, 2048);
      check(boot_bad, 0);
      host.start();
   endtask : do_reset
   // Address, data, then control; result once busy drops
   task automatic op(input logic [15:0] a, input logic [31:0] d,
      input logic [15:0] c, output logic rf, output logic [31:0] q);
      adr = a;
      awe = 1'b1;
      cyc(1);
      awe = 1'b0;
      din = d;
      dwe = 1'b1;
      cyc(1);
      dwe = 1'b0;
      ctl = c;
      cwe = 1'b1;
      cyc(1);
      cwe = 1'b0;
      cyc(6);
      for (int i = 0; i < 1000 && sts[0] !== 1'b0; i++) cyc(1);
      rf = sts[2];
      q = dq;
   endtask : op
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      logic rf, oe;
      logic [31:0] q, d, s1;
      logic [31:0] pd [4];
      {nrst, awe, dwe, cwe} = 4'h0;
      adr = '0;
      din = '0;
      ctl = '0;
      void'($urandom(32'h46b2));
      host.scan(1'b1, 32'h1, q, oe);
      check({31'h0, oe}, 32'h0);
      do_reset();
      check(sec, 32'h0);
      check({30'h0, botp, link}, 32'h1);
      // Scan reset held low after boot keeps the port silent
      host.trst_n_o = 1'b0;
      host.scan(1'b1, 32'h1, q, oe);
      host.scan(1'b0, 32'h0, q, oe);
      check({31'h0, oe}, 32'h0);
      host.start();
      host.scan(1'b1, 32'h1, q, oe);
      host.scan(1'b0, 32'h0, q, oe);
      check(q, {VER, PART, MAKER, 1'b1});
      host.scan(1'b1, 32'h8, q, oe);
      host.scan(1'b0, 32'h0, q, oe);
      check(q, {10'h0, 4'h0, REV});
      // Last row of every sector, then read back
      for (int s = 0; s < 4; s++) begin
         pd[s] = $urandom();
         op({5'h0, s[1:0], 9'h1ff}, pd[s], 16'h1, rf, q);
         check({31'h0, rf}, 32'h0);
         op({5'h0, s[1:0], 9'h1ff}, 32'h0, 16'h2, rf, q);
         check(q, pd[s]);
      end
      d = $urandom();
      op(16'h03ff, d, 16'h1, rf, q);
      op(16'h03ff, 32'h0, 16'h2, rf, q);
      check(q, pd[1] | d);
      op(16'h0805, d, 16'h1, rf, q);
      check({31'h0, rf}, 32'h1);
      s1 = ($urandom() & 32'hffff8000) | 32'h000021a2;
      op(16'h0, s1, 16'h5, rf, q);
      do_reset();
      check(sec, s1);
      check(watch_d, pd[1] | d);
      check({30'h0, botp, link}, 32'h2);
      host.scan(1'b1, 32'h8, q, oe);
      host.scan(1'b0, 32'h0, q, oe);
      check(q, {s1[31:22], 4'h0, REV});
      host.scan(1'b1, 32'h6, q, oe);
      host.scan(1'b0, 32'h3ff, q, oe);
      host.scan(1'b1, 32'h7, q, oe);
      host.scan(1'b0, 32'h0, q, oe);
      check(q, 32'h0);
      op(16'h0000, d, 16'h1, rf, q);
      check({31'h0, rf}, 32'h1);
      op(16'h0600, d, 16'h1, rf, q);
      check({31'h0, rf}, 32'h0);
      op(16'h0805, d, 16'h1, rf, q);
      check({31'h0, rf}, 32'h0);
      op(16'h0, 32'h1001, 16'h5, rf, q);
      do_reset();
      check(sec, s1 | 32'h1001);
      op(16'h0600, d, 16'h1, rf, q);
      check({31'h0, rf}, 32'h1);
      op(16'h0, 32'h4000, 16'h5, rf, q);
      check({31'h0, rf}, 32'h1);
      host.scan(1'b1, 32'h1, q, oe);
      host.scan(1'b0, 32'h0, q, oe);
      check({31'h0, oe}, 32'h0);
      print_verdict();
   end
endmodule : otpsec_tb_top
`default_nettype wire
